/* File: rtc_calendar.sv */
// Function
// - minutes BCD, tens 0-5 in 6:4, units 3:0, bit 7 zero, default 0
// - 12h hours: bit 5 meridiem, bit 4 tens, 3:0 units
// - 24h hours: tens 0-2 in 5:4, units 3:0, bits 7:6 zero
// - hour format chosen by the hour-format select input
// - day of month BCD, tens 5:4, units 3:0, default 1
// - year divisible by four, including zero, gives February 29 days
// - weekday 0-6 in bits 2:0, default Saturday 110
// - month BCD 1-12, tens bit 4, units 3:0, default January
// - year two BCD digits 7:4 and 3:0, default zero
// - counters frozen while a bus access is in progress
// - on release one stored pending increment is applied
// - answer only slave address 1010001; last bit gives direction
// - each byte followed by acknowledge, SDA low during ninth pulse
// - device acknowledges every byte it receives when addressed
// - master leaves last read byte unacknowledged; device releases SDA
// - SDA fall with SCL high is START, rise is STOP
// - SDA stable while SCL high; one bit per clock pulse
// - write transfer ends on STOP or next START
// - only low four pointer bits select the register
// - seconds BCD with bit 7 oscillator-halt flag, default set
// - halt flag set on oscillator stop, clear fails while stopped
`include "rtc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rtc_calendar
   import rtc_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_PERIOD_NS / `SYS_CLK_PERIOD_NS
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic osc_running_i,
   input wire logic hour_mode_12_i
);

   // ==========================================================
   // calendar arithmetic
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction

   function automatic logic is_leap(input logic [7:0] y);
      if (y[4])
         return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
      case (m)
         8'h02: return is_leap(y) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction

   function automatic calendar_t advance(input calendar_t c, input logic m12);
      calendar_t n;
      logic day_end;
      n = c;
      day_end = 1'b0;
      if (c.sec != `SEC_MAX) begin
         n.sec = bcd_inc(c.sec);
      end else begin
         n.sec = 8'h00;
         if (c.min != `SEC_MAX) begin
            n.min = bcd_inc(c.min);
         end else begin
            n.min = 8'h00;
            if (m12) begin
               if (c.hour[4:0] == `HOUR12_LAST) begin
                  n.hour = {2'b00, ~c.hour[`HOUR_PM_BIT], `HOUR12_TOP};
                  day_end = c.hour[`HOUR_PM_BIT];
               end else if (c.hour[4:0] == `HOUR12_TOP) begin
                  n.hour = {2'b00, c.hour[`HOUR_PM_BIT], 5'h01};
               end else begin
                  n.hour = (c.hour & 8'h20) | bcd_inc(c.hour & `HOUR12_MASK);
               end
            end else if (c.hour == `HOUR24_MAX) begin
               n.hour = 8'h00;
               day_end = 1'b1;
            end else begin
               n.hour = bcd_inc(c.hour);
            end
         end
      end
      if (day_end) begin
         n.wday = (c.wday == 8'h06) ? 8'h00 : c.wday + 8'h01;
         if (c.day != month_len(c.mon, c.year)) begin
            n.day = bcd_inc(c.day);
         end else begin
            n.day = 8'h01;
            if (c.mon != `MON_MAX) begin
               n.mon = bcd_inc(c.mon);
            end else begin
               n.mon = 8'h01;
               n.year = (c.year == `YEAR_MAX) ? 8'h00 : bcd_inc(c.year);
            end
         end
      end
      return n;
   endfunction

   // ==========================================================
   // link domain: reset release and pin synchronisers
   logic [1:0] lrst_reg;
   logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
   logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
   wire link_rst_n = lrst_reg[1];

   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lrst_reg <= 2'b00;
      end else begin
         lrst_reg <= {lrst_reg[0], 1'b1};
      end
   end

   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         {scl_meta_reg, scl_sync_reg, scl_prev_reg} <= 3'b111;
         {sda_meta_reg, sda_sync_reg, sda_prev_reg} <= 3'b111;
      end else begin
         {scl_meta_reg, scl_sync_reg, scl_prev_reg} <= {scl_i, scl_meta_reg, scl_sync_reg};
         {sda_meta_reg, sda_sync_reg, sda_prev_reg} <= {sda_i, sda_meta_reg, sda_sync_reg};
      end
   end

   wire scl_high = scl_sync_reg & scl_prev_reg;
   wire scl_rise = scl_sync_reg & ~scl_prev_reg;
   wire scl_fall = ~scl_sync_reg & scl_prev_reg;
   wire start_det = scl_high & sda_prev_reg & ~sda_sync_reg;
   wire stop_det = scl_high & ~sda_prev_reg & sda_sync_reg;

   // ==========================================================
   // link domain: byte engine
   link_state_t state_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg, tx_reg, rd_link_reg;
   logic [1:0] phase_reg;
   logic rw_reg, ack_ok_reg, sda_oe_reg, busy_reg, req_tgl_reg;
   logic [3:0] ptr_reg;
   reg_req_t req_reg;
   logic ack_meta_reg, ack_sync_reg, ack_prev_reg;
   logic ack_tgl_reg;
   logic [7:0] rdata_reg;

   wire [7:0] rx_byte = {shift_reg[6:0], sda_sync_reg};
   wire addr_hit = rx_byte[7:1] == `SLAVE_ADDR;
   wire last_bit = bit_cnt_reg == 3'd7;

   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 3'd0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         phase_reg <= 2'd0;
         rw_reg <= 1'b0;
         ack_ok_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         busy_reg <= 1'b0;
         ptr_reg <= 4'h0;
         req_reg <= '0;
         req_tgl_reg <= 1'b0;
      end else if (stop_det) begin
         state_reg <= ST_IDLE;
         sda_oe_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else if (start_det) begin
         state_reg <= ST_RECV;
         bit_cnt_reg <= 3'd0;
         phase_reg <= 2'd0;
         sda_oe_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
            end
            ST_RECV: if (scl_rise) begin
               shift_reg <= rx_byte;
               bit_cnt_reg <= bit_cnt_reg + 3'd1;
               if (last_bit) begin
                  state_reg <= ST_ACK_DEC;
                  ack_ok_reg <= 1'b1;
                  if (phase_reg != 2'd2) begin
                     phase_reg <= phase_reg + 2'd1;
                  end
                  if (phase_reg == 2'd0) begin
                     ack_ok_reg <= addr_hit;
                     busy_reg <= addr_hit;
                     rw_reg <= rx_byte[0];
                     if (addr_hit && rx_byte[0]) begin
                        req_reg <= '{wr: 1'b0, addr: ptr_reg, data: 8'h00};
                        req_tgl_reg <= ~req_tgl_reg;
                     end
                  end else if (phase_reg == 2'd1) begin
                     ptr_reg <= rx_byte[3:0];
                  end else begin
                     req_reg <= '{wr: 1'b1, addr: ptr_reg, data: rx_byte};
                     req_tgl_reg <= ~req_tgl_reg;
                     ptr_reg <= ptr_reg + 4'h1;
                  end
               end
            end
            ST_ACK_DEC: if (scl_fall) begin
               sda_oe_reg <= ack_ok_reg;
               state_reg <= ack_ok_reg ? ST_ACK : ST_IDLE;
            end
            ST_ACK: if (scl_fall) begin
               if (rw_reg) begin
                  tx_reg <= rd_link_reg;
                  sda_oe_reg <= ~rd_link_reg[7];
                  ptr_reg <= ptr_reg + 4'h1;
                  bit_cnt_reg <= 3'd0;
                  state_reg <= ST_SEND;
               end else begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= ST_RECV;
               end
            end
            ST_SEND: if (scl_fall) begin
               bit_cnt_reg <= bit_cnt_reg + 3'd1;
               tx_reg <= {tx_reg[6:0], 1'b0};
               if (last_bit) begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= ST_RACK;
                  req_reg <= '{wr: 1'b0, addr: ptr_reg, data: 8'h00};
                  req_tgl_reg <= ~req_tgl_reg;
               end else begin
                  sda_oe_reg <= ~tx_reg[6];
               end
            end
            ST_RACK: if (scl_rise) begin
               state_reg <= sda_sync_reg ? ST_IDLE : ST_ACK;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // read data comes back once the answer toggle has crossed
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         {ack_meta_reg, ack_sync_reg, ack_prev_reg} <= 3'b000;
         rd_link_reg <= 8'h00;
      end else begin
         {ack_meta_reg, ack_sync_reg, ack_prev_reg} <= {ack_tgl_reg, ack_meta_reg, ack_sync_reg};
         if (ack_sync_reg != ack_prev_reg) begin
            rd_link_reg <= rdata_reg;
         end
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = sda_oe_reg;

   // ==========================================================
   // system domain: crossings
   logic req_meta_reg, req_sync_reg, req_prev_reg;
   logic busy_meta_reg, frozen_reg;
   logic osc_meta_reg, osc_run_reg;
   logic mode_meta_reg, mode12_reg;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {req_meta_reg, req_sync_reg, req_prev_reg} <= 3'b000;
         {busy_meta_reg, frozen_reg} <= 2'b00;
         {osc_meta_reg, osc_run_reg} <= 2'b00;
         {mode_meta_reg, mode12_reg} <= 2'b00;
      end else begin
         {req_meta_reg, req_sync_reg, req_prev_reg} <= {req_tgl_reg, req_meta_reg, req_sync_reg};
         {busy_meta_reg, frozen_reg} <= {busy_reg, busy_meta_reg};
         {osc_meta_reg, osc_run_reg} <= {osc_running_i, osc_meta_reg};
         {mode_meta_reg, mode12_reg} <= {hour_mode_12_i, mode_meta_reg};
      end
   end

   wire req_evt = req_sync_reg ^ req_prev_reg;
   wire wr_fire = req_evt & req_reg.wr;

   // ==========================================================
   // system domain: 1 Hz tick and counters
   logic [31:0] tick_cnt_reg;
   logic pending_reg, osc_flag_reg;
   calendar_t cal_reg, cal_wr, cal_adv;
   logic [7:0] rd_mux;

   wire tick = osc_run_reg & (tick_cnt_reg == 32'(TICK_CYCLES - 1));
   wire step = ~frozen_reg & (tick | pending_reg);
   wire sec_wr = wr_fire & (req_reg.addr == `SEC_OFS);
   assign cal_adv = advance(cal_reg, mode12_reg);

   always_comb begin
      cal_wr = cal_reg;
      unique case (req_reg.addr)
         `SEC_OFS: cal_wr.sec = req_reg.data & `SEC_MASK;
         `MIN_OFS: cal_wr.min = req_reg.data & `MIN_MASK;
         `HOUR_OFS: cal_wr.hour = req_reg.data & `HOUR_MASK;
         `DAY_OFS: cal_wr.day = req_reg.data & `DAY_MASK;
         `WDAY_OFS: cal_wr.wday = req_reg.data & `WDAY_MASK;
         `MON_OFS: cal_wr.mon = req_reg.data & `MON_MASK;
         `YEAR_OFS: cal_wr.year = req_reg.data;
         default: cal_wr = cal_reg;
      endcase
   end

   always_comb begin
      unique case (req_reg.addr)
         `SEC_OFS: rd_mux = {osc_flag_reg, cal_reg.sec[6:0]};
         `MIN_OFS: rd_mux = cal_reg.min;
         `HOUR_OFS: rd_mux = cal_reg.hour;
         `DAY_OFS: rd_mux = cal_reg.day;
         `WDAY_OFS: rd_mux = cal_reg.wday;
         `MON_OFS: rd_mux = cal_reg.mon;
         `YEAR_OFS: rd_mux = cal_reg.year;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_reg <= 32'h0;
      end else if (tick) begin
         tick_cnt_reg <= 32'h0;
      end else if (osc_run_reg) begin
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending_reg <= 1'b0;
         cal_reg <= '{`YEAR_RST, `MON_RST, `WDAY_RST, `DAY_RST, `HOUR_RST, `MIN_RST, `SEC_RST};
      end else begin
         pending_reg <= frozen_reg & (tick | pending_reg);
         if (wr_fire) begin
            cal_reg <= cal_wr;
         end else if (step) begin
            cal_reg <= cal_adv;
         end
      end
   end

   // set by a stopped oscillator wins over a clearing write
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osc_flag_reg <= 1'b1;
      end else if (!osc_run_reg) begin
         osc_flag_reg <= 1'b1;
      end else if (sec_wr) begin
         osc_flag_reg <= req_reg.data[`OSC_FLAG_BIT];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 8'h00;
         ack_tgl_reg <= 1'b0;
      end else if (req_evt) begin
         if (!req_reg.wr) begin
            rdata_reg <= rd_mux;
         end
         ack_tgl_reg <= ~ack_tgl_reg;
      end
   end

   // ==========================================================
   // checks
   wire rollover_hour = step & ~wr_fire & (cal_reg.min == `SEC_MAX) & (cal_reg.sec == `SEC_MAX);

   a_min_unused: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i) cal_reg.min[7] == 1'b0)
      else $error("minute bit 7 set");
   a_hour12_wrap: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rollover_hour && mode12_reg && cal_reg.hour[4:0] == `HOUR12_LAST) |=>
      (cal_reg.hour[4:0] == `HOUR12_TOP && cal_reg.hour[5] != $past(cal_reg.hour[5])))
      else $error("12h wrap wrong");
   a_hour24_wrap: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rollover_hour && !mode12_reg && cal_reg.hour == `HOUR24_MAX) |=> cal_reg.hour == 8'h00)
      else $error("24h wrap wrong");
   a_leap_feb: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rollover_hour && !mode12_reg && cal_reg.hour == `HOUR24_MAX && cal_reg.mon == 8'h02
       && cal_reg.day == 8'h28 && is_leap(cal_reg.year)) |=> cal_reg.day == 8'h29)
      else $error("leap day missed");
   a_wday_wrap: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      ($changed(cal_reg.day) && !$past(wr_fire) && $past(cal_reg.wday) == 8'h06)
      |-> cal_reg.wday == 8'h00)
      else $error("weekday wrap wrong");
   a_freeze_hold: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (frozen_reg && !wr_fire) |=> $stable(cal_reg))
      else $error("counters moved while frozen");
   a_pending_serve: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (frozen_reg && pending_reg) ##1 !frozen_reg |-> step)
      else $error("pending tick lost");
   a_osc_flag_set: assert property (
      @(posedge sys_clk_i) disable iff (!rst_n_i) !osc_run_reg |=> osc_flag_reg)
      else $error("halt flag not set");
   a_idle_release: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_n) state_reg == ST_IDLE |-> !sda_oe_reg)
      else $error("sda driven while idle");
   a_stop_idle: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_n) stop_det |=> state_reg == ST_IDLE)
      else $error("stop not honoured");
   a_ack_hold: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_n)
      (state_reg == ST_ACK && !rw_reg) |-> sda_oe_reg)
      else $error("receive ack missing");
   a_addr_miss: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_n)
      (state_reg == ST_ACK_DEC && !ack_ok_reg && scl_fall && !start_det && !stop_det)
      |=> (state_reg == ST_IDLE && !sda_oe_reg))
      else $error("foreign address answered");
endmodule
`default_nettype wire

/* File: rtc_map.svh */
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
// register pointer offsets and slave address
`define SEC_OFS 4'h4
`define MIN_OFS 4'h5
`define HOUR_OFS 4'h6
`define DAY_OFS 4'h7
`define WDAY_OFS 4'h8
`define MON_OFS 4'h9
`define YEAR_OFS 4'ha
`define SLAVE_ADDR 7'h51
// field positions and masks
`define OSC_FLAG_BIT 7
`define HOUR_PM_BIT 5
`define SEC_MASK 8'h7f
`define MIN_MASK 8'h7f
`define HOUR_MASK 8'h3f
`define HOUR12_MASK 8'h1f
`define DAY_MASK 8'h3f
`define WDAY_MASK 8'h07
`define MON_MASK 8'h1f
// reset values
`define MIN_RST 8'h00
`define SEC_RST 8'h00
`define HOUR_RST 8'h00
`define DAY_RST 8'h01
`define WDAY_RST 8'h06
`define MON_RST 8'h01
`define YEAR_RST 8'h00
// counting limits
`define SEC_MAX 8'h59
`define HOUR24_MAX 8'h23
`define MON_MAX 8'h12
`define YEAR_MAX 8'h99
`define HOUR12_LAST 5'h11
`define HOUR12_TOP 5'h12
// timing
`define TICK_PERIOD_NS 1000000000
`define SYS_CLK_PERIOD_NS 10
`endif

/* File: rtc_pkg.sv */
package rtc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RECV = 3'b001,
      ST_ACK_DEC = 3'b010,
      ST_ACK = 3'b011,
      ST_SEND = 3'b100,
      ST_RACK = 3'b101
   } link_state_t;
   typedef struct packed {
      logic wr;
      logic [3:0] addr;
      logic [7:0] data;
   } reg_req_t;
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] mon;
      logic [7:0] wday;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } calendar_t;
endpackage

/* File: i2c_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// bus master driving scl and the master share of sda
module i2c_master_model #(
   parameter int LOW_CYC = 40,
   parameter int HIGH_CYC = 20
) (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o,
   output logic got_o,
   output logic [8:0] got_val_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      got_o = 1'b0;
      got_val_o = 9'h000;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // start or repeated start, only from idle bus or scl low
   task automatic start_c();
      sda_o <= 1'b1;
      hold(LOW_CYC / 2);
      scl_o <= 1'b1;
      hold(HIGH_CYC);
      sda_o <= 1'b0;
      hold(HIGH_CYC);
      scl_o <= 1'b0;
      hold(10);
   endtask
   task automatic stop_c();
      sda_o <= 1'b0;
      hold(LOW_CYC / 2);
      scl_o <= 1'b1;
      hold(HIGH_CYC);
      sda_o <= 1'b1;
      hold(HIGH_CYC);
   endtask
   // sda moves only while scl low, well clear of the falling edge
   task automatic bit_c(input logic b, output logic r);
      sda_o <= b;
      hold(LOW_CYC);
      scl_o <= 1'b1;
      hold(HIGH_CYC / 2);
      r = sda_i;
      hold(HIGH_CYC / 2);
      scl_o <= 1'b0;
      hold(10);
   endtask
   // eight bits msb first plus ack; master nacks only the last read
   task automatic xfer(input logic [7:0] d, input bit rd, input bit nack);
      logic [7:0] v;
      logic r;
      v = d;
      for (int i = 7; i >= 0; i--) begin
         bit_c(rd ? 1'b1 : d[i], r);
         v[i] = r;
      end
      bit_c(rd ? nack : 1'b1, r);
      got_val_o <= {rd ? nack : r, v};
      got_o <= 1'b1;
      hold(1);
      got_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb_rtc_calendar_i2c_access.sv */
`include "rtc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_rtc_calendar_i2c_access
   import rtc_pkg::*;
;
`define CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
   localparam int TICKS = 2000;
   logic sys_clk, link_clk, rst_n, osc_run, mode12;
   wire logic scl, m_sda, sda_oe, sda_drv, got;
   wire logic [8:0] got_val;
   wire logic sda_w = (sda_oe ? sda_drv : 1'b1) & m_sda;
   int error_cnt = 0;
   int n_compared = 0;
   logic [8:0] exp_q[$];
   logic [8:0] exp_b;
   logic [55:0] set_v [4];
   logic [55:0] end_v [4];
   logic [3:0] mode_v = 4'b1100;
   logic [7:0] rmin, rhour, rwd;
   rtc_calendar #(.TICK_CYCLES(TICKS)) dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
      .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_drv),
      .sda_oe_o(sda_oe), .osc_running_i(osc_run), .hour_mode_12_i(mode12));
   i2c_master_model m (.clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda),
      .got_o(got), .got_val_o(got_val));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #13;
      forever #32 link_clk = ~link_clk;
   end
   // ==========
   // checker side: oldest note against each byte seen
   always @(posedge sys_clk) begin
      if (got === 1'b1) begin
         exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 9'hxxx;
         `CHK("bus byte", exp_b, got_val)
      end
   end
   task automatic xb(input logic [7:0] d, input bit rd, input bit nack, input logic [8:0] e);
      exp_q.push_back(e);
      m.xfer(d, rd, nack);
   endtask
   task automatic wr_time(input logic [7:0] ptr, input logic [55:0] v);
      m.start_c();
      xb({`SLAVE_ADDR, 1'b0}, 0, 0, {1'b0, `SLAVE_ADDR, 1'b0});
      xb(ptr, 0, 0, {1'b0, ptr});
      for (int i = 6; i >= 0; i--)
         xb(v[i*8 +: 8], 0, 0, {1'b0, v[i*8 +: 8]});
      m.stop_c();
   endtask
   task automatic rd_time(input logic [55:0] v);
      m.start_c();
      xb({`SLAVE_ADDR, 1'b0}, 0, 0, {1'b0, `SLAVE_ADDR, 1'b0});
      xb(8'h04, 0, 0, 9'h004);
      m.start_c();
      xb({`SLAVE_ADDR, 1'b1}, 0, 0, {1'b0, `SLAVE_ADDR, 1'b1});
      for (int i = 6; i >= 0; i--)
         xb(8'hff, 1, i == 0, {i == 0, v[i*8 +: 8]});
      m.stop_c();
   endtask
   task automatic run_ticks(input int n);
      osc_run <= 1'b1;
      repeat (n * TICKS) @(posedge sys_clk);
      osc_run <= 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (120000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end
   // ==========
   // main sequence; ticks are counted only while osc_run is high
   initial begin
      rst_n = 1'b0;
      osc_run = 1'b0;
      mode12 = 1'b0;
      void'($urandom(41485));
      set_v[0] = 56'h59_59_23_28_06_02_04;
      end_v[0] = 56'h80_00_00_29_00_02_04;
      set_v[1] = 56'h59_59_23_28_03_02_03;
      end_v[1] = 56'h80_00_00_01_04_03_03;
      set_v[2] = 56'h59_59_31_31_05_12_99;
      end_v[2] = 56'h80_00_12_01_06_01_00;
      set_v[3] = 56'h59_59_11_15_02_06_20;
      end_v[3] = 56'h80_00_32_15_02_06_20;
      rmin = {1'b0, 3'($urandom % 6), 4'($urandom % 10)};
      rhour = {2'b00, 2'($urandom % 2), 4'($urandom % 10)};
      rwd = 8'($urandom % 7);
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rd_time(56'h80_00_00_01_06_01_00);
      $display("test defaults done");
      m.start_c();
      xb(8'ha4, 0, 0, 9'h1a4);
      m.stop_c();
      $display("test foreign address done");
      for (int c = 0; c < 4; c++) begin
         mode12 <= mode_v[c];
         wr_time(c == 0 ? 8'hf4 : 8'h04, set_v[c]);
         run_ticks(1);
         rd_time(end_v[c]);
         $display("test calendar case %0d done", c);
      end
      mode12 <= 1'b0;
      wr_time(8'h04, {8'h00, rmin, rhour, 8'h15, rwd, 8'h07, 8'h22});
      // exactly one tick lands inside the frozen read
      fork
         rd_time({8'h80, rmin, rhour, 8'h15, rwd, 8'h07, 8'h22});
         begin
            repeat (1000) @(posedge sys_clk);
            osc_run <= 1'b1;
            repeat (TICKS) @(posedge sys_clk);
            osc_run <= 1'b0;
         end
      join
      repeat (20) @(posedge sys_clk);
      rd_time({8'h81, rmin, rhour, 8'h15, rwd, 8'h07, 8'h22});
      $display("test frozen access done");
      summarize();
   end
endmodule
`default_nettype wire
